// ===== udc_counter.sv
module udc_counter
  import udc_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic [1:0]            enable,
  input  wire logic                  cascade,
  input  wire udc_pkg::udc_mode_type mode0,
  input  wire udc_pkg::udc_mode_type mode1,
  input  wire udc_pkg::udc_edge_type edge0,
  input  wire udc_pkg::udc_edge_type edge1,
  input  wire logic [1:0]            rate_slow,
  input  wire logic [1:0]            index_gate,
  input  wire logic [1:0]            cmp_clear_en,
  input  wire logic [1:0]            reload_en,
  input  wire logic [1:0]            cmp_irq_en,
  input  wire logic [1:0]            reload_irq_en,
  input  wire logic [1:0]            ovf_irq_en,
  input  wire logic [1:0]            dir_irq_en,
  input  wire logic [7:0]            compare0,
  input  wire logic [7:0]            compare1,
  input  wire logic [1:0]            flag_clear,
  input  wire logic [1:0]            phase_a_pin,
  input  wire logic [1:0]            phase_b_pin,
  input  wire logic [1:0]            index_input_pin,
  output logic [7:0]                 count0,
  output logic [7:0]                 count1,
  output logic [1:0]                 cmp_flag,
  output logic [1:0]                 udf_flag,
  output logic [1:0]                 ovf_flag,
  output logic [1:0]                 dir_up_flag,
  output logic [1:0]                 dir_chg_flag,
  output logic [1:0]                 irq
);
  // Whole block state
  typedef struct packed {
    logic [2:0]  presc;
    logic [15:0] cnt;
    logic [1:0]  idx;
    logic [1:0]  cmpf;
    logic [1:0]  udff;
    logic [1:0]  ovff;
    logic [1:0]  dirf;
    logic [1:0]  dchf;
    logic [1:0]  irq;
  } udc_state_type;

  udc_state_type st_r;
  udc_state_type st_nxt;
  logic [1:0]    step;      // Raw count pulse per channel
  logic [1:0]    up;        // Raw direction per channel
  logic          tick_fast; // Div by 2 enable
  logic          tick_slow; // Div by 8 enable

  // Divided timer enables from one prescaler
  assign tick_fast = (st_r.presc[0] == 1'(UDC_DIV_FAST - 1));
  assign tick_slow = (st_r.presc == 3'(UDC_DIV_SLOW - 1));

  udc_pulse_gen u_pg0 (
    .clock     (clock),
    .reset     (reset),
    .mode      (mode0),
    .edge_sel  (edge0),
    .tick_fast (tick_fast),
    .tick_slow (tick_slow),
    .rate_slow (rate_slow[0]),
    .ain       (phase_a_pin[0]),
    .bin       (phase_b_pin[0]),
    .step      (step[0]),
    .up        (up[0])
  );

  udc_pulse_gen u_pg1 (
    .clock     (clock),
    .reset     (reset),
    .mode      (mode1),
    .edge_sel  (edge1),
    .tick_fast (tick_fast),
    .tick_slow (tick_slow),
    .rate_slow (rate_slow[1]),
    .ain       (phase_a_pin[1]),
    .bin       (phase_b_pin[1]),
    .step      (step[1]),
    .up        (up[1])
  );

  // Step one channel; returns {udf, ovf, cmp, value}
  function automatic logic [18:0] step_cnt(input logic [15:0] v, input logic [15:0] top,
                                           input logic [15:0] cmp, input logic dn,
                                           input logic clr, input logic rld);
    logic [15:0] n;
    logic        u;
    logic        o;
    logic        c;
    n = v;
    u = 1'b0;
    o = 1'b0;
    c = 1'b0;
    if (dn) begin
      if (v == 16'h0000) begin
        u = 1'b1;
        n = rld ? cmp : top;
      end else begin
        n = v - 16'h0001;
      end
    end else begin
      if (v == top) begin
        o = 1'b1;
        n = 16'h0000;
      end else begin
        n = v + 16'h0001;
      end
    end
    if (!u && (n == cmp)) begin
      c = 1'b1;
      if (clr) begin
        n = 16'h0000;
      end
    end
    return {u, o, c, n};
  endfunction

  // Next-state logic
  always_comb begin
    logic [1:0]  go;
    logic [1:0]  zclr;
    logic [18:0] r0;
    logic [18:0] r1;
    logic [1:0]  ev_c;
    logic [1:0]  ev_u;
    logic [1:0]  ev_o;
    logic [1:0]  ev_d;
    go     = '0;
    zclr   = '0;
    r0     = '0;
    r1     = '0;
    ev_c   = '0;
    ev_u   = '0;
    ev_o   = '0;
    ev_d   = '0;
    st_nxt = st_r;
    st_nxt.presc = st_r.presc + 3'h1;
    st_nxt.idx   = index_input_pin;
    for (int i = 0; i < 2; i++) begin
      // Index pin gates by level or clears on rising edge
      go[i]   = enable[i] & step[i] & (~index_gate[i] | index_input_pin[i]);
      zclr[i] = ~index_gate[i] & index_input_pin[i] & ~st_r.idx[i];
    end
    if (cascade) begin
      // Channel 0 source drives the joined 16-bit count
      r0 = step_cnt(st_r.cnt, 16'hFFFF, {compare1, compare0}, ~up[0],
                    cmp_clear_en[0], reload_en[0]);
      if (zclr[0]) begin
        st_nxt.cnt = 16'h0000;
      end else if (go[0]) begin
        st_nxt.cnt = r0[15:0];
        {ev_u[0], ev_o[0], ev_c[0]} = r0[18:16];
        ev_d[0] = (up[0] != st_r.dirf[0]);
        st_nxt.dirf[0] = up[0];
      end
    end else begin
      r0 = step_cnt({8'h00, st_r.cnt[7:0]}, {8'h00, UDC_CNT_MAX}, {8'h00, compare0},
                    ~up[0], cmp_clear_en[0], reload_en[0]);
      r1 = step_cnt({8'h00, st_r.cnt[15:8]}, {8'h00, UDC_CNT_MAX}, {8'h00, compare1},
                    ~up[1], cmp_clear_en[1], reload_en[1]);
      // Independent 8-bit channels
      if (zclr[0]) begin
        st_nxt.cnt[7:0] = UDC_CNT_RST;
      end else if (go[0]) begin
        st_nxt.cnt[7:0] = r0[7:0];
        {ev_u[0], ev_o[0], ev_c[0]} = r0[18:16];
        ev_d[0] = (up[0] != st_r.dirf[0]);
        st_nxt.dirf[0] = up[0];
      end
      if (zclr[1]) begin
        st_nxt.cnt[15:8] = UDC_CNT_RST;
      end else if (go[1]) begin
        st_nxt.cnt[15:8] = r1[7:0];
        {ev_u[1], ev_o[1], ev_c[1]} = r1[18:16];
        ev_d[1] = (up[1] != st_r.dirf[1]);
        st_nxt.dirf[1] = up[1];
      end
    end
    // Sticky flags; a new event beats a clear in the same cycle
    st_nxt.cmpf = (st_r.cmpf & ~flag_clear) | ev_c;
    st_nxt.udff = (st_r.udff & ~flag_clear) | ev_u;
    st_nxt.ovff = (st_r.ovff & ~flag_clear) | ev_o;
    st_nxt.dchf = (st_r.dchf & ~flag_clear) | ev_d;
    // Separately enabled interrupt sources
    st_nxt.irq = (st_nxt.cmpf & cmp_irq_en) | (st_nxt.udff & reload_irq_en & reload_en)
               | (st_nxt.ovff & ovf_irq_en) | (st_nxt.dchf & dir_irq_en);
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      // Index level tracked in reset, so a high pin is no clear edge after release
      st_r <= '{presc: UDC_PRESC_RST, cnt: 16'h0000, idx: index_input_pin, dirf: 2'h3,
                default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign count0       = st_r.cnt[7:0];
  assign count1       = st_r.cnt[15:8];
  assign cmp_flag     = st_r.cmpf;
  assign udf_flag     = st_r.udff;
  assign ovf_flag     = st_r.ovff;
  assign dir_up_flag  = st_r.dirf;
  assign dir_chg_flag = st_r.dchf;
  assign irq          = st_r.irq;
endmodule

// ===== udc_pkg.sv
package udc_pkg;
  // Count source modes
  typedef enum logic [1:0] {
    UDC_MODE_TIMER = 2'h0,
    UDC_MODE_EDGE  = 2'h1,
    UDC_MODE_PH_X2 = 2'h2,
    UDC_MODE_PH_X8 = 2'h3
  } udc_mode_type;

  // Edge selection for up/down count mode
  typedef enum logic [1:0] {
    UDC_EDGE_NONE = 2'h0,
    UDC_EDGE_FALL = 2'h1,
    UDC_EDGE_RISE = 2'h2,
    UDC_EDGE_BOTH = 2'h3
  } udc_edge_type;

  localparam int    UDC_W           = 8;          // Channel width
  localparam int    UDC_CLK_HZ      = 20000000;   // Machine clock rate
  localparam int    UDC_DIV_FAST    = 2;          // Timer rate divide by 2
  localparam int    UDC_DIV_SLOW    = 8;          // Timer rate divide by 8
  localparam logic [2:0] UDC_PRESC_RST = 3'h0;    // Prescaler reset value
  localparam logic [7:0] UDC_CNT_RST   = 8'h00;   // Counter reset value
  localparam logic [7:0] UDC_CNT_MAX   = 8'hFF;   // Top count of a channel
endpackage

// ===== udc_pulse_gen.sv
// Per-channel count pulse and direction generator
module udc_pulse_gen
  import udc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire udc_pkg::udc_mode_type mode,
  input  wire udc_pkg::udc_edge_type edge_sel,
  input  wire logic              tick_fast,
  input  wire logic              tick_slow,
  input  wire logic              rate_slow,
  input  wire logic              ain,
  input  wire logic              bin,
  output logic                   step,
  output logic                   up
);
  // Previous pin levels for edge detection
  typedef struct packed {
    logic a;
    logic b;
  } udc_pg_state_type;

  udc_pg_state_type st_r;
  udc_pg_state_type st_nxt;
  logic             a_rise;
  logic             a_fall;
  logic             b_rise;
  logic             b_fall;

  // Edge detect and step decode
  always_comb begin
    st_nxt = '{a: ain, b: bin};
    a_rise = ain & ~st_r.a;
    a_fall = ~ain & st_r.a;
    b_rise = bin & ~st_r.b;
    b_fall = ~bin & st_r.b;
    step   = 1'b0;
    up     = 1'b1;
    // One of four count sources per channel
    case (mode)
      UDC_MODE_TIMER: begin
        step = rate_slow ? tick_slow : tick_fast;
      end
      UDC_MODE_EDGE: begin
        // A edges count up, B edges count down
        case (edge_sel)
          UDC_EDGE_FALL: begin
            step = a_fall | b_fall;
            up   = a_fall;
          end
          UDC_EDGE_RISE: begin
            step = a_rise | b_rise;
            up   = a_rise;
          end
          UDC_EDGE_BOTH: begin
            step = a_rise | a_fall | b_rise | b_fall;
            up   = a_rise | a_fall;
          end
          default: begin
            step = 1'b0;
          end
        endcase
      end
      UDC_MODE_PH_X2: begin
        // Count on A edges, B level gives direction
        step = a_rise | a_fall;
        up   = a_rise ? ~bin : bin;
      end
      UDC_MODE_PH_X8: begin
        // Count every edge of both phases
        step = a_rise | a_fall | b_rise | b_fall;
        up   = (a_rise | a_fall) ? (ain ^ bin) : ~(ain ^ bin);
      end
      default: begin
        step = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      // Track the pins in reset, so a pin left high gives no false edge
      st_r <= '{a: ain, b: bin};
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ===== udc_counter_monitor.sv
// Checker on the top ports; channel 0 relations, single clock domain
module udc_counter_monitor (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [1:0] enable,
  input wire logic       cascade,
  input wire logic [1:0] index_gate,
  input wire logic [1:0] cmp_clear_en,
  input wire logic [1:0] reload_en,
  input wire logic [7:0] compare0,
  input wire logic [7:0] count0,
  input wire logic [1:0] cmp_flag,
  input wire logic [1:0] udf_flag,
  input wire logic [1:0] ovf_flag,
  input wire logic [1:0] dir_up_flag,
  input wire logic [1:0] dir_chg_flag,
  input wire logic [1:0] irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  AST_RESET_STATE: assert property ($fell(reset) |-> count0 == 8'h00 && irq == 2'h0
    && dir_up_flag == 2'h3) else $error("bad state after reset");
  AST_HOLD_OFF: assert property (!enable[0] && index_gate[0] && !cascade
    |=> $stable(count0)) else $error("count moved while disabled");
  AST_CMP_KEEP: assert property ($rose(cmp_flag[0]) && !cascade && !$past(cmp_clear_en[0])
    |-> count0 == $past(compare0)) else $error("compare match altered count");
  AST_CMP_CLEAR: assert property ($rose(cmp_flag[0]) && !cascade && $past(cmp_clear_en[0])
    |-> count0 == 8'h00) else $error("compare match did not clear");
  AST_UDF_LOAD: assert property ($rose(udf_flag[0]) && !cascade
    |-> count0 == ($past(reload_en[0]) ? $past(compare0) : 8'hFF)) else $error("bad underflow");
  AST_OVF_WRAP: assert property ($rose(ovf_flag[0]) && !cascade
    |-> count0 == 8'h00 && $past(count0) == 8'hFF) else $error("bad overflow wrap");
  AST_DIR_CHANGE: assert property ($changed(dir_up_flag[0]) && !$past(reset)
    |-> dir_chg_flag[0]) else $error("reversal not flagged");
  AST_IRQ_QUIET: assert property ({cmp_flag[0], udf_flag[0], ovf_flag[0], dir_chg_flag[0]}
    == 4'h0 |-> !irq[0]) else $error("request without a flag");
  // Main scenarios seen at all
  cover property ($rose(ovf_flag[0]));
  cover property ($rose(udf_flag[0]) && reload_en[0]);
  cover property ($rose(dir_chg_flag[0]));
endmodule
bind udc_counter udc_counter_monitor u_mon (.clock(clock), .reset(reset), .enable(enable),
  .cascade(cascade), .index_gate(index_gate), .cmp_clear_en(cmp_clear_en),
  .reload_en(reload_en), .compare0(compare0), .count0(count0), .cmp_flag(cmp_flag),
  .udf_flag(udf_flag), .ovf_flag(ovf_flag), .dir_up_flag(dir_up_flag),
  .dir_chg_flag(dir_chg_flag), .irq(irq));

// ===== udc_enc_src.sv
// Event source or quadrature encoder on the pulse pins
module udc_enc_src (
  input  wire logic clock,
  input  wire logic quad,
  input  wire logic fwd,
  input  wire logic rev,
  output logic      a,
  output logic      b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph_r = 2'h0; // Encoder phase
  logic       ea_r = 1'b0; // Event line A level
  logic       eb_r = 1'b0; // Event line B level
  // One line edge per cycle of fwd or rev alone, so no step is lost to coincidence
  always @(posedge clock) begin
    ph_r <= ph_r + {1'b0, quad & fwd} - {1'b0, quad & rev};
    ea_r <= ea_r ^ (fwd & ~quad);
    eb_r <= eb_r ^ (rev & ~quad);
  end
  // Forward walks 00,10,11,01 on (a,b): A leads B
  assign a = quad ? ph_r[1] ^ ph_r[0] : ea_r;
  assign b = quad ? ph_r[1] : eb_r;
endmodule

// ===== tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import udc_pkg::*;
  logic clock = 1'b0, reset = 1'b1, cascade = 1'b0, fwd = 1'b0, rev = 1'b0, quad = 1'b0, pa, pb;
  logic [1:0] enable = 2'h3, rate_slow = 2'h0, index_gate = 2'h0, idx = 2'h0, flag_clear = 2'h0;
  logic [1:0] cmp_clear_en = 2'h0, reload_en = 2'h0, cmp_irq_en = 2'h0, ovf_irq_en = 2'h0;
  logic [1:0] dir_irq_en = 2'h0, cmp_flag, udf_flag, ovf_flag, dir_up_flag, dir_chg_flag, irq;
  logic [7:0] cmpv = 8'h03, count0, count1, c; // Compare value shared by both channels
  udc_mode_type mode = UDC_MODE_EDGE;
  udc_edge_type edg  = UDC_EDGE_BOTH;
  int fails = 0, checks_done = 0;
  udc_enc_src src (.clock(clock), .quad(quad), .fwd(fwd), .rev(rev), .a(pa), .b(pb));
  // Channel 1 mirrors channel 0; flag checks cover both, count checks read one channel
  udc_counter dut (.clock(clock), .reset(reset), .enable(enable), .cascade(cascade),
    .mode0(mode), .mode1(mode), .edge0(edg), .edge1(edg), .rate_slow(rate_slow),
    .index_gate(index_gate), .cmp_clear_en(cmp_clear_en), .reload_en(reload_en),
    .cmp_irq_en(cmp_irq_en), .reload_irq_en(reload_en), .ovf_irq_en(ovf_irq_en),
    .dir_irq_en(dir_irq_en), .compare0(cmpv), .compare1(cmpv), .flag_clear(flag_clear),
    .phase_a_pin({2{pa}}), .phase_b_pin({2{pb}}), .index_input_pin(idx), .count0(count0),
    .count1(count1), .cmp_flag(cmp_flag), .udf_flag(udf_flag), .ovf_flag(ovf_flag),
    .dir_up_flag(dir_up_flag), .dir_chg_flag(dir_chg_flag), .irq(irq));
  always #25 clock = ~clock;
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Pulse n cycles, then let pin sync and count settle
  task automatic run(input logic f, input logic r, input int n);
    @(posedge clock);
    fwd <= f;
    rev <= r;
    repeat (n) @(posedge clock);
    fwd <= 1'b0;
    rev <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
  endtask
  // New setup under reset; ie picks compare, overflow, reversal requests
  task automatic cfg(input udc_mode_type m, input udc_edge_type e, input logic cc,
                     input logic rl, input logic [2:0] ie);
    @(posedge clock);
    mode <= m;
    edg <= e;
    reset <= 1'b1;
    {cmp_clear_en, reload_en} <= {{2{cc}}, {2{rl}}};
    {cmp_irq_en, ovf_irq_en, dir_irq_en} <= {{2{ie[2]}}, {2{ie[1]}}, {2{ie[0]}}};
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1;
  endtask
  // Cut a hang short
  initial begin
    repeat (10000) @(posedge clock);
    fails++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    check("rst_dir", {6'h00, dir_up_flag}, 8'h03);
    for (int e = 0; e < 4; e++) begin
      cfg(UDC_MODE_EDGE, udc_edge_type'(e), 1'b0, 1'b0, 3'h0);
      run(1'b1, 1'b0, 2);
      check("edge", count1, 8'(e - e / 2));
    end
    cfg(UDC_MODE_EDGE, UDC_EDGE_BOTH, 1'b0, 1'b0, 3'h1);
    run(1'b1, 1'b0, 3);
    run(1'b0, 1'b1, 1);
    check("down", count0, 8'h02);
    check("dir", {6'h00, dir_up_flag}, 8'h00);
    check("dirchg", {dir_chg_flag, irq, 4'h0}, 8'hF0);
    for (int k = 0; k < 2; k++) begin
      cfg(UDC_MODE_EDGE, UDC_EDGE_BOTH, 1'b0, 1'b0, {k[0], 2'h0});
      run(1'b1, 1'b0, 3);
      check("cmp", {count0[3:0], cmp_flag, irq}, {8'h3C | 8'(k * 3)});
    end
    cfg(UDC_MODE_EDGE, UDC_EDGE_BOTH, 1'b1, 1'b0, 3'h0);
    run(1'b1, 1'b0, 3);
    check("cmpclr", {count0[5:0], cmp_flag}, 8'h03);
    cfg(UDC_MODE_EDGE, UDC_EDGE_BOTH, 1'b0, 1'b1, 3'h0);
    run(1'b0, 1'b1, 1);
    check("reload", {count0[5:0], udf_flag}, 8'h0F);
    check("reload_irq", {6'h00, irq}, 8'h03);
    cfg(UDC_MODE_EDGE, UDC_EDGE_BOTH, 1'b0, 1'b0, 3'h0);
    run(1'b0, 1'b1, 1);
    check("under", count0, 8'hFF);
    cfg(UDC_MODE_EDGE, UDC_EDGE_BOTH, 1'b1, 1'b1, 3'h0);
    run(1'b1, 1'b0, 3);
    run(1'b0, 1'b1, 1);
    check("both", count0, 8'h03);
    cfg(UDC_MODE_EDGE, UDC_EDGE_BOTH, 1'b0, 1'b0, 3'h2);
    run(1'b1, 1'b0, 256);
    check("ovf", {count0[3:0], ovf_flag, irq}, 8'h0F);
    @(posedge clock);
    flag_clear <= 2'h3;
    @(posedge clock);
    flag_clear <= 2'h0;
    run(1'b0, 1'b0, 0);
    check("fclr", {4'h0, ovf_flag, cmp_flag}, 8'h00);
    @(posedge clock);
    cascade <= 1'b1;
    cfg(UDC_MODE_EDGE, UDC_EDGE_BOTH, 1'b0, 1'b0, 3'h0);
    run(1'b1, 1'b0, 256);
    check("c16", count1 ^ count0, 8'h01);
    @(posedge clock);
    cascade <= 1'b0;
    cfg(UDC_MODE_EDGE, UDC_EDGE_BOTH, 1'b0, 1'b0, 3'h0);
    run(1'b1, 1'b0, 2);
    @(posedge clock);
    idx <= 2'h3;
    run(1'b0, 1'b0, 0);
    check("iclr", count0, 8'h00);
    @(posedge clock);
    {idx, index_gate} <= 4'h3;
    run(1'b1, 1'b0, 2);
    check("gate", count0, 8'h00);
    @(posedge clock);
    idx <= 2'h3;
    run(1'b1, 1'b0, 2);
    check("open", count0, 8'h02);
    @(posedge clock);
    enable <= 2'h0;
    run(1'b1, 1'b0, 2);
    check("off", count0, 8'h02);
    @(posedge clock);
    {enable, idx, index_gate, quad} <= 7'h61;
    cfg(UDC_MODE_TIMER, UDC_EDGE_NONE, 1'b0, 1'b0, 3'h0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      rate_slow <= {2{k[0]}};
      repeat (8) @(negedge clock);
      c = count0;
      repeat (32) @(negedge clock);
      c = count0 - c;
      check("timer", c, 8'(16 >> (2 * k)));
    end
    cfg(UDC_MODE_PH_X2, UDC_EDGE_NONE, 1'b0, 1'b0, 3'h0);
    run(1'b1, 1'b0, 4);
    check("x2", count0, 8'h02);
    run(1'b0, 1'b1, 4);
    check("x2dn", {count0[5:0], dir_up_flag}, 8'h00);
    cfg(UDC_MODE_PH_X8, UDC_EDGE_NONE, 1'b0, 1'b0, 3'h0);
    run(1'b1, 1'b0, 4);
    check("x8", count0, 8'h04);
    complete_run();
  end
endmodule
